// ### hw/flash_host_pkg.sv
// Constants and types shared by the parallel flash host controller.
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_ACCESS_NS = 120;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_HOLD_NS = 30;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_RECOVER_NS = 50;
  localparam int T_PROTECT_PULSE_US = 100;
  localparam int SYNC_STAGES = 2;

  // Rounds a least time up to whole clock cycles, never below one.
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  localparam int ADDR_SETUP_CYC = ns_to_cycles(T_ADDR_SETUP_NS);
  localparam int ACCESS_CYC = ns_to_cycles(T_ACCESS_NS) + SYNC_STAGES;
  localparam int WRITE_PULSE_CYC = ns_to_cycles(T_WRITE_PULSE_NS);
  localparam int HOLD_CYC = ns_to_cycles(T_HOLD_NS);
  localparam int RESET_PULSE_CYC = ns_to_cycles(T_RESET_PULSE_NS);
  localparam int RESET_RECOVER_CYC = ns_to_cycles(T_RESET_RECOVER_NS);
  localparam int PROTECT_PULSE_CYC = ns_to_cycles(T_PROTECT_PULSE_US * 1000);

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int TMR_W = 16;
  localparam int SEL_A6 = 6;
  localparam int SEL_A1 = 1;
  localparam int SEL_A0 = 0;
  localparam int SHARED_PIN = 15;

  // ----------------------------------------------------------------
  // Operations requested on the user port
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_BYPASS_PROG,
    OP_PROTECT,
    OP_UNPROTECT,
    OP_HW_RESET
  } flash_op_t;

endpackage : flash_host_pkg

// ### hw/flash_timer_if.sv
// Interface carrying load and expiry between the controller and its cycle timer.
`timescale 1ns/1ps
interface flash_timer_if;
  logic load;
  logic [15:0] load_val;
  logic expired;

  modport ctrl (output load, output load_val, input expired);
  modport timer (input load, input load_val, output expired);
endinterface : flash_timer_if

// ### hw/flash_cycle_timer.sv
// Down counter that times each phase of a flash bus cycle.
`timescale 1ns/1ps
module flash_cycle_timer
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Control
  flash_timer_if.timer tmr
);

  logic [TMR_W-1:0] count_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_r <= '0;
    end else if (tmr.load) begin
      count_r <= tmr.load_val - 16'h0001;
    end else if (count_r != '0) begin
      count_r <= count_r - 16'h0001;
    end
  end

  // A load of N expires N cycles later.
  // Expiry depends on the count alone, so it never loops back through the load decode.
  assign tmr.expired = (count_r == '0);

endmodule : flash_cycle_timer

// ### hw/flash_bus_host.sv
// Host-side controller that drives a parallel flash through its bus pins.
`timescale 1ns/1ps
module flash_bus_host
  import flash_host_pkg::*;
#(
  parameter int PROTECT_CYC = PROTECT_PULSE_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // User request port
  input wire logic req_i,
  input wire flash_op_t op_i,
  input wire logic byte_mode_i,
  input wire logic [ADDR_W:0] addr_i,
  input wire logic [7:0] cmd_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic ready_o,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic dev_busy_o,
  // Flash control pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic reset_n_o,
  output logic high_voltage_reset_level_o,
  output logic byte_n_o,
  output logic [ADDR_W-1:0] addr_o,
  // Flash data pins
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  input wire logic ready_busy_n_i
);

  // ----------------------------------------------------------------
  // State and request registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_RST_LOW,
    ST_RST_REC
  } host_state_t;

  host_state_t state_r, state_nxt;
  flash_op_t op_r;
  logic byte_r;
  logic phase_r;
  logic [ADDR_W:0] addr_r;
  logic [7:0] cmd_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic rb_s1_r, rb_s2_r;
  logic done_r;

  flash_timer_if tmr ();

  flash_cycle_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .tmr(tmr)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire take = (state_r == ST_IDLE) && req_i;
  // In the take cycle the pins already follow the new request, not the previous one.
  wire flash_op_t op_cur = take ? op_i : op_r;
  wire byte_cur = take ? byte_mode_i : byte_r;
  wire phase_cur = take ? 1'b0 : phase_r;
  wire [ADDR_W:0] addr_cur = take ? addr_i : addr_r;
  wire [7:0] cmd_cur = take ? cmd_i : cmd_r;
  wire [DATA_W-1:0] wdata_cur = take ? wdata_i : wdata_r;
  wire is_read = (op_cur == OP_READ);
  wire is_prot = (op_cur == OP_PROTECT) || (op_cur == OP_UNPROTECT);
  wire req_reset = (op_i == OP_HW_RESET);
  wire second_write = (op_cur == OP_BYPASS_PROG) && !phase_cur;
  wire [TMR_W-1:0] strobe_len = is_read ? TMR_W'(ACCESS_CYC) :
                                is_prot ? TMR_W'(PROTECT_CYC) : TMR_W'(WRITE_PULSE_CYC);

  // First bypass cycle sends the command, the second sends the data.
  wire [DATA_W-1:0] wr_word = (op_cur == OP_BYPASS_PROG && !phase_cur) ?
                              {8'h00, cmd_cur} : wdata_cur;

  // Protection forces the selector bits onto the sector address.
  wire [ADDR_W-1:0] word_addr = byte_cur ? addr_cur[ADDR_W:1] : addr_cur[ADDR_W-1:0];
  wire [ADDR_W-1:0] prot_addr = {word_addr[ADDR_W-1:SEL_A6+1], (op_cur == OP_UNPROTECT),
                                 word_addr[SEL_A6-1:SEL_A1+1], 1'b1, 1'b0};

  always_comb begin
    state_nxt = state_r;
    tmr.load = 1'b0;
    tmr.load_val = '0;
    case (state_r)
      ST_IDLE: begin
        if (req_i) begin
          tmr.load = 1'b1;
          if (req_reset) begin
            state_nxt = ST_RST_LOW;
            tmr.load_val = TMR_W'(RESET_PULSE_CYC);
          end else begin
            state_nxt = ST_SETUP;
            tmr.load_val = TMR_W'(ADDR_SETUP_CYC);
          end
        end
      end
      ST_SETUP: begin
        if (tmr.expired) begin
          state_nxt = ST_STROBE;
          tmr.load = 1'b1;
          tmr.load_val = strobe_len;
        end
      end
      ST_STROBE: begin
        if (tmr.expired) begin
          state_nxt = ST_HOLD;
          tmr.load = 1'b1;
          tmr.load_val = TMR_W'(HOLD_CYC);
        end
      end
      ST_HOLD: begin
        if (tmr.expired) begin
          tmr.load = second_write;
          tmr.load_val = TMR_W'(ADDR_SETUP_CYC);
          state_nxt = second_write ? ST_SETUP : ST_IDLE;
        end
      end
      ST_RST_LOW: begin
        if (tmr.expired) begin
          state_nxt = ST_RST_REC;
          tmr.load = 1'b1;
          tmr.load_val = TMR_W'(RESET_RECOVER_CYC);
        end
      end
      ST_RST_REC: begin
        if (tmr.expired) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the next state so every pin leaves a flip-flop.
  wire nxt_active = (state_nxt == ST_SETUP) || (state_nxt == ST_STROBE) || (state_nxt == ST_HOLD);
  wire nxt_strobe = (state_nxt == ST_STROBE);
  wire nxt_write = !is_read && nxt_active;
  wire nxt_ce_n = !nxt_active;
  wire nxt_oe_n = !(nxt_strobe && is_read);
  wire nxt_we_n = !(nxt_strobe && !is_read);
  wire nxt_rst_n = !(state_nxt == ST_RST_LOW);
  wire nxt_hv = is_prot && nxt_active;
  wire [DATA_W-1:0] nxt_oe_mask = byte_cur ? 16'h80FF : 16'hFFFF;
  wire [DATA_W-1:0] nxt_dq_oe = (nxt_write ? nxt_oe_mask : 16'h0000) |
                                ((byte_cur && nxt_active) ? 16'h8000 : 16'h0000);
  wire [DATA_W-1:0] nxt_dq = byte_cur ? {addr_cur[0], 7'h00, wr_word[7:0]} : wr_word;
  wire capture = (state_r == ST_STROBE) && tmr.expired && is_read;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_IDLE;
      op_r <= OP_READ;
      byte_r <= 1'b0;
      phase_r <= 1'b0;
      addr_r <= '0;
      cmd_r <= 8'h00;
      wdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        op_r <= op_i;
        byte_r <= byte_mode_i;
        phase_r <= 1'b0;
        addr_r <= addr_i;
        cmd_r <= cmd_i;
        wdata_r <= wdata_i;
      end else if (state_r == ST_HOLD && tmr.expired) begin
        phase_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      reset_n_o <= 1'b1;
      high_voltage_reset_level_o <= 1'b0;
      byte_n_o <= 1'b1;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= '0;
    end else begin
      ce_n_o <= nxt_ce_n;
      oe_n_o <= nxt_oe_n;
      we_n_o <= nxt_we_n;
      reset_n_o <= nxt_rst_n;
      high_voltage_reset_level_o <= nxt_hv;
      byte_n_o <= !byte_cur;
      addr_o <= is_prot ? prot_addr : word_addr;
      dq_o <= nxt_dq;
      dq_oe_o <= nxt_dq_oe;
    end
  end

  // Data and ready pins come from outside the clock domain.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
      rdata_o <= '0;
      done_r <= 1'b0;
    end else begin
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_n_i;
      rb_s2_r <= rb_s1_r;
      if (capture) begin
        rdata_o <= byte_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
      end
      done_r <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
    end
  end

  assign done_o = done_r;
  assign ready_o = (state_r == ST_IDLE);
  assign dev_busy_o = !rb_s2_r;

endmodule : flash_bus_host

// ### testbench/flash_bus_host_chk.sv
// Assertions on the pins of the flash bus host.
`timescale 1ns/1ps
module flash_bus_host_chk
  import flash_host_pkg::*;
(
  // Clock, reset and requests
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic req_i,
  input wire flash_op_t op_i,
  input wire logic ready_o,
  input wire logic done_o,
  // Flash pins
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic reset_n_o,
  input wire logic high_voltage_reset_level_o,
  input wire logic byte_n_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic [DATA_W-1:0] dq_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_take(flash_op_t k);
    req_i && ready_o && op_i == k;
  endsequence
  a_read_strobes: assert property (!oe_n_o |-> !ce_n_o && we_n_o && reset_n_o)
    else $error("read strobes wrong");
  a_write_strobes: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
    else $error("write strobes wrong");
  a_write_data: assert property (!we_n_o && !high_voltage_reset_level_o |-> &dq_oe_o[7:0])
    else $error("write data not driven");
  a_byte_float: assert property (!byte_n_o |-> dq_oe_o[14:8] == 7'h00)
    else $error("middle pins driven in byte mode");
  a_byte_lsb: assert property (!byte_n_o && !ce_n_o && !high_voltage_reset_level_o
    |-> dq_oe_o[SHARED_PIN])
    else $error("address lsb not driven");
  a_read_release: assert property (!oe_n_o |-> dq_oe_o[14:0] == 15'h0000
    && (byte_n_o -> !dq_oe_o[SHARED_PIN]))
    else $error("host drives data during read");
  a_protect_addr: assert property (high_voltage_reset_level_o && !we_n_o
    |-> addr_o[SEL_A1] && !addr_o[SEL_A0] && oe_n_o)
    else $error("protect address levels wrong");
  a_unprotect_a6: assert property (s_take(OP_UNPROTECT) |-> ##[2:4] (!we_n_o
    && high_voltage_reset_level_o && addr_o[SEL_A6]))
    else $error("unprotect levels wrong");
  a_reset_quiet: assert property (!reset_n_o |-> ce_n_o && oe_n_o && we_n_o)
    else $error("strobes active during reset");
  a_read_done: assert property (s_take(OP_READ) |-> ##[20:21] done_o)
    else $error("read done late");
  a_write_pulse: assert property (s_take(OP_WRITE) |=> we_n_o [*2] ##[1:3] !we_n_o)
    else $error("write pulse misplaced");
endmodule : flash_bus_host_chk

bind flash_bus_host flash_bus_host_chk i_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
  .req_i(req_i), .op_i(op_i), .ready_o(ready_o), .done_o(done_o), .ce_n_o(ce_n_o),
  .oe_n_o(oe_n_o), .we_n_o(we_n_o), .reset_n_o(reset_n_o), .byte_n_o(byte_n_o),
  .high_voltage_reset_level_o(high_voltage_reset_level_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o));

// ### testbench/flash_dev_model.sv
// Behavioural parallel flash device answering the host pins.
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int ACC_NS = 60
) (
  // Control pins
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic hv_i,
  input wire logic byte_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // Data pins
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic [DATA_W-1:0] dq_oe_o,
  output logic ready_busy_n_o
);
  logic [DATA_W-1:0] mem [16];
  wire [3:0] idx = addr_i[3:0];
  wire rd = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
  wire [7:0] rbyte = dq_i[SHARED_PIN] ? mem[idx][15:8] : mem[idx][7:0];
  initial begin
    ready_busy_n_o = 1'b1;
    for (int i = 0; i < 16; i++) mem[i] = 16'(16'h1111 * i);
  end
  // No command state is kept, so reads always return the array.
  assign #(ACC_NS) dq_o = byte_n_i ? mem[idx] : {8'h00, rbyte};
  assign #(ACC_NS) dq_oe_o = !rd ? 16'h0000 : (byte_n_i ? 16'hFFFF : 16'h00FF);
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && reset_n_i && !hv_i) begin
      if (byte_n_i) mem[idx] = dq_i;
      else if (dq_i[SHARED_PIN]) mem[idx][15:8] = dq_i[7:0];
      else mem[idx][7:0] = dq_i[7:0];
      ready_busy_n_o = 1'b0;
      ready_busy_n_o <= #200 1'b1;
    end
  end
endmodule : flash_dev_model

// ### testbench/tb.sv
// Self-checking bench for the flash bus host against a device model.
`timescale 1ns/1ps
module tb;
  import flash_host_pkg::*;
  localparam int PCYC = 4;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_i = 1'b0;
  flash_op_t op_i = OP_READ;
  logic byte_mode_i = 1'b0;
  logic [ADDR_W:0] addr_i = '0;
  logic [7:0] cmd_i = 8'h00;
  logic [DATA_W-1:0] wdata_i = '0;
  logic pat = 1'b0;
  logic ready_o, done_o, dev_busy_o, ce_n_o, oe_n_o, we_n_o, reset_n_o, hv, byte_n_o, rb_n;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_oe_o, dev_dq, dev_oe, dq_bus;
  logic [ADDR_W-1:0] addr_o;
  logic [ADDR_W:0] a;
  logic [DATA_W-1:0] d;
  logic bm;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // Released lines show a pattern that changes every cycle.
  always @(posedge ref_clk_i) pat <= ~pat;
  assign dq_bus = (dq_oe_o & dq_o) | (~dq_oe_o & dev_oe & dev_dq)
    | (~dq_oe_o & ~dev_oe & {8{pat, ~pat}});
  flash_bus_host #(.PROTECT_CYC(PCYC)) i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .req_i(req_i), .op_i(op_i), .byte_mode_i(byte_mode_i), .addr_i(addr_i), .cmd_i(cmd_i),
    .wdata_i(wdata_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .dev_busy_o(dev_busy_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
    .reset_n_o(reset_n_o), .high_voltage_reset_level_o(hv), .byte_n_o(byte_n_o),
    .addr_o(addr_o), .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .ready_busy_n_i(rb_n));
  flash_dev_model i_dev (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .reset_n_i(reset_n_o), .hv_i(hv), .byte_n_i(byte_n_o), .addr_i(addr_o), .dq_i(dq_bus),
    .dq_o(dev_dq), .dq_oe_o(dev_oe), .ready_busy_n_o(rb_n));
  function automatic logic [DATA_W-1:0] exp_init(input int i);
    return 16'(16'h1111 * i);
  endfunction : exp_init
  // Cycles from the take edge to the edge that raises done, from the timing constants.
  function automatic int exp_lat(input flash_op_t op);
    case (op)
      OP_READ: return ADDR_SETUP_CYC + ACCESS_CYC + HOLD_CYC;
      OP_BYPASS_PROG: return 2 * (ADDR_SETUP_CYC + WRITE_PULSE_CYC + HOLD_CYC);
      OP_PROTECT, OP_UNPROTECT: return ADDR_SETUP_CYC + PCYC + HOLD_CYC;
      OP_HW_RESET: return RESET_PULSE_CYC + RESET_RECOVER_CYC;
      default: return ADDR_SETUP_CYC + WRITE_PULSE_CYC + HOLD_CYC;
    endcase
  endfunction : exp_lat
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Issues one operation, waits for done and checks its latency in cycles.
  task automatic run(input flash_op_t op, input logic b, input logic [ADDR_W:0] ad,
                     input logic [DATA_W-1:0] dat, input int lat);
    int n;
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    op_i <= op;
    byte_mode_i <= b;
    addr_i <= ad;
    wdata_i <= dat;
    cmd_i <= dat[15:8];
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 2000);
    check("latency", 16'(lat), 16'(n));
  endtask : run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'hB082));
    repeat (12) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    #1;
    check("idle ce_n", 16'h0001, {15'h0000, ce_n_o});
    check("idle dq_oe", 16'h0000, dq_oe_o);
    check("idle ready", 16'h0001, {15'h0000, ready_o});
    for (int i = 0; i < 4; i++) begin
      run(OP_READ, 1'b0, 20'(i), 16'h0000, exp_lat(OP_READ));
      check("first read", exp_init(i), rdata_o);
    end
    for (int k = 0; k < 10; k++) begin
      a = 20'($urandom);
      d = 16'($urandom);
      bm = 1'($urandom);
      run(OP_WRITE, bm, a, d, exp_lat(OP_WRITE));
      check("busy after write", 16'h0001, {15'h0000, dev_busy_o});
      run(OP_READ, bm, a, 16'h0000, exp_lat(OP_READ));
      check("busy cleared", 16'h0000, {15'h0000, dev_busy_o});
      check("rdata", bm ? {8'h00, d[7:0]} : d, rdata_o);
      if (!bm) begin
        run(OP_READ, 1'b1, {a[18:0], 1'b1}, 16'h0000, exp_lat(OP_READ));
        check("high byte", {8'h00, d[15:8]}, rdata_o);
      end
    end
    run(OP_BYPASS_PROG, 1'b0, a, ~d, exp_lat(OP_BYPASS_PROG));
    run(OP_READ, 1'b0, a, 16'h0000, exp_lat(OP_READ));
    check("bypass", ~d, rdata_o);
    run(OP_PROTECT, 1'b0, a, d, exp_lat(OP_PROTECT));
    run(OP_UNPROTECT, 1'b0, a, d, exp_lat(OP_UNPROTECT));
    run(OP_HW_RESET, 1'b0, a, d, exp_lat(OP_HW_RESET));
    run(OP_READ, 1'b0, a, 16'h0000, exp_lat(OP_READ));
    check("after reset", ~d, rdata_o);
    print_verdict();
  end
endmodule : tb
